/* File: design/pmcr_regs.v */
// Port link-status-2, slot-2 and PM capability registers on Wishbone
//
// Overview of operation
// - At 5.0 Gbps de-emphasis bit reads 0 for -6.0 dB, 1 for -3.5 dB.
// - At 2.5 Gbps the de-emphasis status bit has no defined meaning.
// - Slot capability/control/status two and link status two 15:1 read zero.
// - PM capability bits 7:0 read the constant 0x1.
// - Upstream port: next capability pointer resets to 0x0.
// - Downstream port: next capability pointer resets to 0xD0.
// - PM interface revision bits 18:16 read the constant 0x3.
// - Wake clock flag bit 19 and reserved bit 20 read zero.
// - Device specific init flag bit 21 resets to zero, lockable writable.
// - Auxiliary current field bits 24:22 reads zero.
// - Light and deeper sleep support bits 25 and 26 read zero.
// - Wake message state mask bits 31:27 resets to 0b11001.
// - No wake messages are forwarded while in D3cold.
// - Writing the wake mask changes only the advertised value.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module pmcr_regs
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone classic slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [11:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Port strap and link state
  input  wire        port_downstream_i,
  input  wire        link_speed_5g_i,
  input  wire        deemph_3p5_i,
  // Power state and wake events
  input  wire [1:0]  pm_state_i,
  input  wire        d3cold_i,
  input  wire        wake_event_i,
  // Wake message out
  output wire        wake_msg_o,
  // Advertised wake mask, for the capability consumer
  output reg  [4:0]  wake_mask_o
);

`include "pmcr_map.vh"

// ****************************************************************
// Declarations
// ****************************************************************
  // Bus decode and write strobes
  wire        req;
  wire        wr_commit;
  wire [9:0]  idx;
  wire        hit_ls2;
  wire        hit_scap2;
  wire        hit_sctl2;
  wire        hit_ssts2;
  wire        hit_pmc;
  wire        hit_ctl;
  wire        hit_sts;
  wire        unlocked;
  wire        wr_ptr;
  wire        wr_init;
  wire        wr_mask;
  wire        wr_lock;

  // Captured link and power state
  reg         deemph_q;
  reg         downstream_q;
  reg         speed_5g_q;
  reg  [1:0]  pm_state_q;
  reg         d3cold_q;
  reg         lock_q;
  // Lockable capability fields and their next values
  reg  [7:0]  nxt_ptr_q;
  reg  [7:0]  nxt_ptr_d;
  reg         dev_init_q;
  reg         dev_init_d;
  reg  [4:0]  wake_mask_d;
  reg  [31:0] pmc_word;
  reg  [31:0] sts_word;
  reg  [31:0] rd_word;

// ****************************************************************
// Bus decode
// ****************************************************************
  assign req       = cyc_i & stb_i;
  // Write lands on the edge where the master sees ack high
  assign wr_commit = req & we_i & ack_o;
  assign idx       = adr_i[11:2];

  // Unmapped indices are still acked; they read zero and drop writes
  assign hit_ls2   = (idx == `PMCR_IDX_LINK_STATUS_TWO);
  assign hit_scap2 = (idx == `PMCR_IDX_SLOT_CAP_TWO);
  assign hit_sctl2 = (idx == `PMCR_IDX_SLOT_CONTROL_TWO);
  assign hit_ssts2 = (idx == `PMCR_IDX_SLOT_STATUS_TWO);
  assign hit_pmc   = (idx == `PMCR_IDX_PM_CAPABILITIES);
  assign hit_ctl   = (idx == `PMCR_IDX_PORT_CONTROL);
  assign hit_sts   = (idx == `PMCR_IDX_PORT_STATUS);

  assign unlocked  = ~lock_q;

// ****************************************************************
// Write strobes per byte lane
// ****************************************************************
  // Only byte lanes that hold writable bits are honoured; the lock
  // itself is never locked, or firmware could not undo it
  assign wr_ptr    = wr_commit & hit_pmc & unlocked & sel_i[1];
  assign wr_init   = wr_commit & hit_pmc & unlocked & sel_i[2];
  assign wr_mask   = wr_commit & hit_pmc & unlocked & sel_i[3];
  assign wr_lock   = wr_commit & hit_ctl & sel_i[0];

// ****************************************************************
// Bus handshake
// ****************************************************************
  // One wait-free answer: ack one cycle after the request, then drop
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o)
      begin
        dat_o <= rd_word;
      end
    end
  end

// ****************************************************************
// Link and power state capture
// ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      deemph_q     <= 1'b0;
      speed_5g_q   <= 1'b0;
      downstream_q <= 1'b0;
      pm_state_q   <= 2'h0;
      d3cold_q     <= 1'b0;
    end
    else
    begin
      // Strap and power state copies feed only the status register
      speed_5g_q   <= link_speed_5g_i;
      downstream_q <= port_downstream_i;
      pm_state_q   <= pm_state_i;
      d3cold_q     <= d3cold_i;
      // Level only tracked at 5.0 Gbps; at 2.5 the last value is held
      if (link_speed_5g_i)
      begin
        deemph_q <= deemph_3p5_i;
      end
    end
  end

// ****************************************************************
// Lock control register
// ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_q <= `PMCR_LOCK_RST;
    end
    else if (wr_lock)
    begin
      lock_q <= dat_i[`PMCR_CTL_LOCK_BIT];
    end
  end

// ****************************************************************
// Lockable writable capability fields
// ****************************************************************
  always @*
  begin
    nxt_ptr_d   = nxt_ptr_q;
    dev_init_d  = dev_init_q;
    wake_mask_d = wake_mask_o;
    if (wr_ptr)
    begin
      nxt_ptr_d = dat_i[`PMCR_PMC_NEXT_PTR_LSB +: 8];
    end
    if (wr_init)
    begin
      dev_init_d = dat_i[`PMCR_PMC_DEVINIT_BIT];
    end
    if (wr_mask)
    begin
      wake_mask_d = dat_i[`PMCR_PMC_WAKEMASK_LSB +: 5];
    end
  end

  // Pointer reset value follows the port strap sampled in reset
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      if (port_downstream_i)
      begin
        nxt_ptr_q <= `PMCR_NEXT_PTR_DOWN_RST;
      end
      else
      begin
        nxt_ptr_q <= `PMCR_NEXT_PTR_UP_RST;
      end
      dev_init_q  <= `PMCR_DEVINIT_RST;
      wake_mask_o <= `PMCR_WAKE_MASK_RST;
    end
    else
    begin
      nxt_ptr_q   <= nxt_ptr_d;
      dev_init_q  <= dev_init_d;
      wake_mask_o <= wake_mask_d;
    end
  end

// ****************************************************************
// Capability word assembly
// ****************************************************************
  always @*
  begin
    // Every constant field is forced here, so no stray write leaks in
    pmc_word = 32'h0000_0000;
    pmc_word[`PMCR_PMC_CAP_ID_LSB +: 8]   = `PMCR_CAP_ID_VAL;
    pmc_word[`PMCR_PMC_NEXT_PTR_LSB +: 8] = nxt_ptr_q;
    pmc_word[`PMCR_PMC_REV_LSB +: 3]      = `PMCR_REV_VAL;
    pmc_word[`PMCR_PMC_WAKECLK_BIT]       = 1'b0;
    pmc_word[`PMCR_PMC_RSVD20_BIT]        = 1'b0;
    pmc_word[`PMCR_PMC_DEVINIT_BIT]       = dev_init_q;
    pmc_word[`PMCR_PMC_AUX_CUR_LSB +: 3]  = 3'h0;
    pmc_word[`PMCR_PMC_LIGHT_BIT]         = 1'b0;
    pmc_word[`PMCR_PMC_DEEPER_BIT]        = 1'b0;
    pmc_word[`PMCR_PMC_WAKEMASK_LSB +: 5] = wake_mask_o;
  end

// ****************************************************************
// Port status word
// ****************************************************************
  // One cycle behind the pins, like every other captured state
  always @*
  begin
    sts_word = 32'h0000_0000;
    sts_word[`PMCR_STS_SPEED_BIT]      = speed_5g_q;
    sts_word[`PMCR_STS_DOWN_BIT]       = downstream_q;
    sts_word[`PMCR_STS_STATE_LSB +: 2] = pm_state_q;
    sts_word[`PMCR_STS_COLD_BIT]       = d3cold_q;
  end

// ****************************************************************
// Read multiplexer
// ****************************************************************
  // Reserved registers have no storage, so writes there vanish
  always @*
  begin
    rd_word = 32'h0000_0000;
    if (hit_ls2)
    begin
      rd_word[`PMCR_LS2_DEEMPH_BIT] = deemph_q;
    end
    else if (hit_scap2 | hit_sctl2 | hit_ssts2)
    begin
      rd_word = 32'h0000_0000;
    end
    else if (hit_pmc)
    begin
      rd_word = pmc_word;
    end
    else if (hit_ctl)
    begin
      rd_word[`PMCR_CTL_LOCK_BIT] = lock_q;
    end
    else if (hit_sts)
    begin
      rd_word = sts_word;
    end
  end

// ****************************************************************
// Wake message forwarding
// ****************************************************************
  // Forwarding uses the fixed default mask, never the advertised one,
  // so a written mask changes what is advertised, not what is sent
  pmcr_wake_gate pmcr_wake_gate_i
  (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .pm_state_i   (pm_state_i),
    .d3cold_i     (d3cold_i),
    .wake_event_i (wake_event_i),
    .wake_msg_o   (wake_msg_o)
  );

endmodule // pmcr_regs

/* File: design/pmcr_map.vh */
// Register map, field positions and reset values of the port PM registers
`ifndef PMCR_MAP_VH
`define PMCR_MAP_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PMCR_IDX_LINK_STATUS_TWO    10'h072
`define PMCR_IDX_SLOT_CAP_TWO       10'h074
`define PMCR_IDX_SLOT_CONTROL_TWO   10'h078
`define PMCR_IDX_SLOT_STATUS_TWO    10'h07a
`define PMCR_IDX_PM_CAPABILITIES    10'h0c0
`define PMCR_IDX_PORT_CONTROL       10'h0f0
`define PMCR_IDX_PORT_STATUS        10'h0f4

// ****************************************************************
// Field positions
// ****************************************************************
`define PMCR_LS2_DEEMPH_BIT         0
`define PMCR_PMC_CAP_ID_LSB         0
`define PMCR_PMC_NEXT_PTR_LSB       8
`define PMCR_PMC_REV_LSB            16
`define PMCR_PMC_WAKECLK_BIT        19
`define PMCR_PMC_RSVD20_BIT         20
`define PMCR_PMC_DEVINIT_BIT        21
`define PMCR_PMC_AUX_CUR_LSB        22
`define PMCR_PMC_LIGHT_BIT          25
`define PMCR_PMC_DEEPER_BIT         26
`define PMCR_PMC_WAKEMASK_LSB       27
`define PMCR_CTL_LOCK_BIT           0
`define PMCR_STS_SPEED_BIT          0
`define PMCR_STS_DOWN_BIT           1
`define PMCR_STS_STATE_LSB          2
`define PMCR_STS_COLD_BIT           4

// ****************************************************************
// Reset and constant values
// ****************************************************************
`define PMCR_CAP_ID_VAL             8'h01
`define PMCR_NEXT_PTR_UP_RST        8'h00
`define PMCR_NEXT_PTR_DOWN_RST      8'hd0
`define PMCR_REV_VAL                3'h3
`define PMCR_DEVINIT_RST            1'h0
`define PMCR_WAKE_MASK_RST          5'h19
`define PMCR_LOCK_RST               1'h0

`endif

/* File: design/pmcr_wake_gate.v */
// Wake message gate: forwards wake events per the reset-default state mask
`timescale 1ns/1ps
module pmcr_wake_gate
(
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Power state and wake event
  input  wire [1:0] pm_state_i,
  input  wire       d3cold_i,
  input  wire       wake_event_i,
  // Forwarded wake message
  output reg        wake_msg_o
);

`include "pmcr_map.vh"

  // Fixed mask: bit n stands for Dn; bit 4 (D3cold) is never read, d3cold_i always blocks
  wire [4:0] fixed_mask;
  reg        allowed;

  assign fixed_mask = `PMCR_WAKE_MASK_RST;

  // Software writes to the advertised mask never reach here, by design
  always @*
  begin
    case (pm_state_i)
      2'h0:    allowed = fixed_mask[0];
      2'h1:    allowed = fixed_mask[1];
      2'h2:    allowed = fixed_mask[2];
      2'h3:    allowed = fixed_mask[3];
      default: allowed = 1'b0;
    endcase
    if (d3cold_i)
    begin
      allowed = 1'b0;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_msg_o <= 1'b0;
    end
    else
    begin
      wake_msg_o <= wake_event_i & allowed;
    end
  end

endmodule // pmcr_wake_gate

/* File: verif/pmcr_regs_chk.sv */
// Concurrent checks on the port PM register bank ports
`timescale 1ns/1ps
module pmcr_regs_chk
(
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Bus
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [11:0] adr_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  // Power state and wake
  input wire [1:0]  pm_state_i,
  input wire        d3cold_i,
  input wire        wake_event_i,
  input wire        wake_msg_o,
  input wire [4:0]  wake_mask_o
);
  // ****
  // Helpers
  // ****
  wire [9:0] idx = adr_i[11:2];
  wire       rd  = ack_o && !we_i;
  wire       pm  = rd && idx == 10'h0c0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // Properties
  // ****
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  property p_capability_identifier; pm |-> dat_o[7:0] == 8'h01; endproperty
  a_capability_identifier: assert property (p_capability_identifier) else $error("cap id");
  property p_ver; pm |-> dat_o[18:16] == 3'h3; endproperty
  a_ver: assert property (p_ver) else $error("revision");
  property p_b19; pm |-> dat_o[20:19] == 2'h0; endproperty
  a_b19: assert property (p_b19) else $error("bits 20:19");
  property p_aux; pm |-> dat_o[26:22] == 5'h00; endproperty
  a_aux: assert property (p_aux) else $error("bits 26:22");
  property p_mask; pm |-> dat_o[31:27] == wake_mask_o; endproperty
  a_mask: assert property (p_mask) else $error("mask field");
  property p_slot;
    rd && (idx == 10'h074 || idx == 10'h078 || idx == 10'h07a) |-> !dat_o;
  endproperty
  a_slot: assert property (p_slot) else $error("slot regs");
  property p_ls2; rd && idx == 10'h072 |-> dat_o[31:1] == 31'h0; endproperty
  a_ls2: assert property (p_ls2) else $error("link status two");
  property p_cold; d3cold_i |=> !wake_msg_o; endproperty
  a_cold: assert property (p_cold) else $error("wake in D3cold");
  property p_wake;
    wake_event_i && !d3cold_i && (pm_state_i == 2'h0 || pm_state_i == 2'h3)
      |=> wake_msg_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake lost");
  property p_nowk; pm_state_i == 2'h1 || pm_state_i == 2'h2 |=> !wake_msg_o;
  endproperty
  a_nowk: assert property (p_nowk) else $error("wake in D1/D2");
  c_pm: cover property (pm);
  c_wr: cover property (ack_o && we_i);
  c_wk: cover property (wake_msg_o);
endmodule // pmcr_regs_chk
bind pmcr_regs pmcr_regs_chk pmcr_regs_chk_i
(
  .clk_i        (clk_i),
  .rst_i        (rst_i),
  .cyc_i        (cyc_i),
  .stb_i        (stb_i),
  .we_i         (we_i),
  .adr_i        (adr_i),
  .dat_o        (dat_o),
  .ack_o        (ack_o),
  .pm_state_i   (pm_state_i),
  .d3cold_i     (d3cold_i),
  .wake_event_i (wake_event_i),
  .wake_msg_o   (wake_msg_o),
  .wake_mask_o  (wake_mask_o)
);

/* File: verif/test_pmcr_regs.sv */
// Directed testbench for the port PM register bank
`timescale 1ns/1ps
module test_pmcr_regs;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, wake_msg_o;
  logic port_downstream_i = 0, link_speed_5g_i = 1, deemph_3p5_i = 0;
  logic [1:0] pm_state_i = 2'h0;
  logic d3cold_i = 0, wake_event_i = 0;
  logic [4:0] wake_mask_o;
  int mismatches = 0, num_checks = 0, cycles = 0, i;
  logic [31:0] r;
  logic [11:0] ro_adr [4] = '{12'h1c8, 12'h1d0, 12'h1e0, 12'h1e8};
  pmcr_regs pmcr_regs_i
  (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .cyc_i             (cyc_i),
    .stb_i             (stb_i),
    .we_i              (we_i),
    .adr_i             (adr_i),
    .sel_i             (sel_i),
    .dat_i             (dat_i),
    .dat_o             (dat_o),
    .ack_o             (ack_o),
    .port_downstream_i (port_downstream_i),
    .link_speed_5g_i   (link_speed_5g_i),
    .deemph_3p5_i      (deemph_3p5_i),
    .pm_state_i        (pm_state_i),
    .d3cold_i          (d3cold_i),
    .wake_event_i      (wake_event_i),
    .wake_msg_o        (wake_msg_o),
    .wake_mask_o       (wake_mask_o)
  );
  always #5 clk_i = ~clk_i;
  // ****
  // Helpers
  // ****
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Sticking point is a hung ack, so bound the whole run
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      summarize;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    wb(0, a, 32'h0);
    chk($sformatf("reg %h", a), e, r);
  endtask
  task do_reset(input logic dn);
    @(posedge clk_i);
    port_downstream_i <= dn;
    rst_i <= 1;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
  endtask
  // ****
  // Scenarios
  // ****
  task t_up;
    do_reset(0);
    rc(12'h300, 32'hc8030001);
    chk("mask out", 32'h19, {27'h0, wake_mask_o});
    for (i = 0; i < 4; i++) rc(ro_adr[i], 32'h0);
    rc(12'h200, 32'h0);
  endtask
  task t_down;
    do_reset(1);
    rc(12'h300, 32'hc803d001);
  endtask
  task t_deemph;
    deemph_3p5_i <= 1;
    repeat (3) @(posedge clk_i);
    rc(12'h1c8, 32'h1);
    deemph_3p5_i <= 0;
    repeat (3) @(posedge clk_i);
    rc(12'h1c8, 32'h0);
    link_speed_5g_i <= 0;
    deemph_3p5_i <= 1;
    repeat (3) @(posedge clk_i);
    wb(0, 12'h1c8, 32'h0);
    chk("ls2 upper", 32'h0, r & 32'hfffffffe);
    link_speed_5g_i <= 1;
    deemph_3p5_i <= 0;
  endtask
  task t_ro;
    for (i = 0; i < 4; i++) wb(1, ro_adr[i], 32'hffffffff);
    for (i = 0; i < 4; i++) rc(ro_adr[i], 32'h0);
    wb(1, 12'h300, 32'hffffffff);
    rc(12'h300, 32'hf823ff01);
    chk("mask out", 32'h1f, {27'h0, wake_mask_o});
    wb(1, 12'h3c0, 32'h1);
    rc(12'h3c0, 32'h1);
    wb(1, 12'h300, 32'h0);
    rc(12'h300, 32'hf823ff01);
    rc(12'h3d0, 32'hf);
  endtask
  // Fifth pass is D3hot with the cold flag raised
  task t_wake;
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk_i);
      pm_state_i <= (i == 4) ? 2'h3 : i[1:0];
      d3cold_i <= (i == 4);
      wake_event_i <= 1;
      repeat (2) @(posedge clk_i);
      chk($sformatf("wake %0d", i), {31'h0, i == 0 || i == 3},
          {31'h0, wake_msg_o});
      wake_event_i <= 0;
      d3cold_i <= 0;
    end
  endtask
  initial
  begin
    t_up;
    t_down;
    t_wake;
    t_deemph;
    t_ro;
    t_wake;
    summarize;
  end
endmodule // test_pmcr_regs
